// [design/tks_pkg.sv]
package tks_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_KEYEN     = 4'h1;
    localparam logic [3:0] REG_THDIR     = 4'h2;
    localparam logic [3:0] REG_FLAGS     = 4'h3;
    localparam logic [3:0] REG_IRQ_STAT  = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK  = 4'h5;
    localparam logic [3:0] REG_SLOTLEN   = 4'h6;
    localparam logic [3:0] REG_LOWTH     = 4'h7;
    localparam logic [3:0] REG_UPTH      = 4'h8;
    localparam logic [3:0] REG_SCANS     = 4'h9;
    localparam logic [3:0] REG_CFDATA0   = 4'hA;

    // CTRL fields
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_MODE_LSB    = 1;
    localparam int CTRL_SLOT1_BIT   = 3;

    // FLAGS fields (write 1 to clear; BUSY is read-only)
    localparam int FLG_SLOT_OV      = 0;
    localparam int FLG_CF_OV        = 1;
    localparam int FLG_REF_OV       = 2;
    localparam int FLG_BUSY         = 3;

    // Interrupt status fields
    localparam int IRQ_SCAN_DONE    = 0;
    localparam int IRQ_THRESH       = 1;
    localparam int IRQ_W            = 2;

    // Mode field encodings
    localparam logic [1:0] MODE_AUTO     = 2'h0;
    localparam logic [1:0] MODE_MANUAL   = 2'h1;

    localparam int NKEYS            = 4;
    localparam int CNT_W            = 16;
    localparam int UNIT_W           = 5;
    localparam int SLOT_W           = 8;

    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] SLOTLEN_RST = 16'h00FF;
    localparam logic [15:0] SCANS_RST   = 16'h0004;
    localparam logic [15:0] LOWTH_RST   = 16'h0000;
    localparam logic [15:0] UPTH_RST    = 16'hFFFF;

    typedef enum logic [1:0]
    {
        TKS_MODE_AUTO,
        TKS_MODE_MANUAL,
        TKS_MODE_PERIODIC
    } tks_mode_t;

    typedef struct packed
    {
        logic       ref_ov;
        logic       cf_ov;
        logic       slot_end;
    } tks_cnt_ev_t;

endpackage

// [design/tks_slot_counter.sv]
`timescale 1ns/1ps

// Counter bank of one time slot: key C/F counter, reference counter,
// unit period prescaler and programmable slot counter.
module tks_slot_counter #(
    parameter int CNT_W  = 16,
    parameter int UNIT_W = 5,
    parameter int SLOT_W = 8
)(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                run,
    input  wire logic                clr_fast,
    input  wire logic                clr_all,
    input  wire logic                key_tick,
    input  wire logic                ref_tick,
    input  wire logic [SLOT_W-1:0]   slot_len,
    output      logic [CNT_W-1:0]    cf_count,
    output      tks_pkg::tks_cnt_ev_t ev
);

    logic [CNT_W-1:0]  ref_cnt_r;
    logic [UNIT_W-1:0] unit_cnt_r;
    logic [SLOT_W-1:0] slot_cnt_r;
    logic              unit_wrap;
    logic              slot_wrap;

    assign unit_wrap = run && ref_tick && (unit_cnt_r == {UNIT_W{1'b1}});
    assign slot_wrap = unit_wrap && (slot_cnt_r == slot_len);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cf_count <= '0;
        else if (clr_fast || clr_all)
            cf_count <= '0;
        else if (run && key_tick)
            cf_count <= cf_count + 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_cnt_r  <= '0;
            unit_cnt_r <= '0;
        end
        else if (clr_fast || clr_all)
        begin
            ref_cnt_r  <= '0;
            unit_cnt_r <= '0;
        end
        else if (run && ref_tick)
        begin
            ref_cnt_r  <= ref_cnt_r + 1'b1;
            unit_cnt_r <= unit_cnt_r + 1'b1;
        end
    end

    // Slot counter survives a start-bit clear; only its own wrap or clr_all clears it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            slot_cnt_r <= '0;
        else if (clr_all || slot_wrap)
            slot_cnt_r <= '0;
        else if (unit_wrap)
            slot_cnt_r <= slot_cnt_r + 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ev <= '0;
        else
        begin
            ev.slot_end <= slot_wrap && !clr_all && !clr_fast;
            ev.cf_ov    <= run && key_tick && (cf_count == {CNT_W{1'b1}});
            ev.ref_ov   <= run && ref_tick && (ref_cnt_r == {CNT_W{1'b1}});
        end
    end

endmodule

// [design/tks_scan_flags.sv]
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - Manual mode: slot counter overflow sets the slot overflow flag and scan-done request.
// - Auto mode: a slot overflow before the sequence ends does not set the slot flag.
// - Auto mode: end of the whole sequence sets slot flag and scan-done request.
// - Periodic mode: slot flag is held at zero while the scan period runs.
// - Periodic mode: only the count of the last slot of the final scan of the period is stored; flags set with it.
// - Scan completion clears all four counters.
// - Periodic mode: threshold event when count below lower (direction 0) or above upper (direction 1).
// - Slot overflow flag stays set until software clears it or a periodic scan runs.
// - Sticky C/F counter overflow flag, cleared only by software.
// - Sticky reference counter overflow flag, cleared only by software.
// - Scan-done and threshold interrupts are separate sources with own requests.
// - Only software-enabled keys are scanned.
// - Mode 00 is auto scan, 10 or 11 is periodic auto scan.
// - Clearing start clears C/F, reference and unit counters, not the slot counter.
module tks_scan_flags #(
    parameter int NKEYS = tks_pkg::NKEYS
)(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [3:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output      logic [15:0]          rdata,
    input  wire logic                 key_tick,
    input  wire logic                 ref_tick,
    input  wire logic                 period_tick,
    output      logic [NKEYS-1:0]     osc_enable,
    output      logic                 osc_sync,
    output      logic                 irq
);

    tks_pkg::tks_mode_t     mode;
    tks_pkg::tks_cnt_ev_t   ev;
    logic [15:0]            ctrl_r;
    logic [NKEYS-1:0]       keyen_r;
    logic [NKEYS-1:0]       thdir_r;
    logic [NKEYS-1:0]       thflag_r;
    logic [15:0]            slotlen_r;
    logic [15:0]            lowth_r;
    logic [15:0]            upth_r;
    logic [15:0]            scans_r;
    logic [15:0]            scan_cnt_r;
    logic                   start_d_r;
    logic                   busy_r;
    logic [1:0]             slot_r;
    logic                   slot_ov_r;
    logic                   cf_ov_r;
    logic                   ref_ov_r;
    logic [tks_pkg::IRQ_W-1:0] irq_stat_r;
    logic [tks_pkg::IRQ_W-1:0] irq_mask_r;
    logic [15:0]            cf_mem [NKEYS];
    logic [15:0]            cf_count;
    logic                   start_rise;
    logic                   start_fall;
    logic                   slot_last;
    logic                   seq_end;
    logic                   scan_done;
    logic                   thr_hit;
    logic                   run;
    logic [1:0]             next_slot;
    logic                   last_slot_only;

    function automatic tks_pkg::tks_mode_t decode_mode(input logic [1:0] f);
        if (f[1])
            decode_mode = tks_pkg::TKS_MODE_PERIODIC;
        else if (f == tks_pkg::MODE_MANUAL)
            decode_mode = tks_pkg::TKS_MODE_MANUAL;
        else
            decode_mode = tks_pkg::TKS_MODE_AUTO;
    endfunction

    function automatic logic wr_hit(input logic [3:0] a);
        wr_hit = wr && (addr == a);
    endfunction

    // First enabled slot at or after a given index; 0 when there is none
    function automatic logic [1:0] first_en(input logic [1:0] from, input logic [NKEYS-1:0] en);
        logic [1:0] r;
        r = 2'h0;
        for (int i = NKEYS - 1; i >= 0; i--)
            if (en[i] && (2'(i) >= from))
                r = 2'(i);
        first_en = r;
    endfunction

    assign mode           = decode_mode(ctrl_r[tks_pkg::CTRL_MODE_LSB +: 2]);
    assign start_rise     = ctrl_r[tks_pkg::CTRL_START_BIT] && !start_d_r;
    assign start_fall     = !ctrl_r[tks_pkg::CTRL_START_BIT] && start_d_r;
    assign run            = busy_r;
    assign last_slot_only = ctrl_r[tks_pkg::CTRL_SLOT1_BIT];
    assign next_slot      = first_en(slot_r + 2'h1, keyen_r);
    assign slot_last      = last_slot_only || (next_slot <= slot_r)
                            || !(|(keyen_r >> (slot_r + 2'h1)));
    assign seq_end        = ev.slot_end && slot_last;
    assign scan_done      = seq_end && ((mode != tks_pkg::TKS_MODE_PERIODIC)
                            || (scan_cnt_r + 16'h1 >= scans_r));
    assign thr_hit        = ev.slot_end && (mode == tks_pkg::TKS_MODE_PERIODIC)
                            && (thdir_r[slot_r] ? (cf_count > upth_r)
                                                : (cf_count < lowth_r));

    tks_slot_counter #(
        .CNT_W  (tks_pkg::CNT_W),
        .UNIT_W (tks_pkg::UNIT_W),
        .SLOT_W (tks_pkg::SLOT_W)
    ) u_cnt (
        .clk      (clk),
        .resetn   (resetn),
        .run      (run),
        .clr_fast (start_fall),
        .clr_all  (ev.slot_end),
        .key_tick (key_tick),
        .ref_tick (ref_tick),
        .slot_len (slotlen_r[tks_pkg::SLOT_W-1:0]),
        .cf_count (cf_count),
        .ev       (ev)
    );

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r    <= tks_pkg::CTRL_RST;
            keyen_r   <= '0;
            thdir_r   <= '0;
            slotlen_r <= tks_pkg::SLOTLEN_RST;
            lowth_r   <= tks_pkg::LOWTH_RST;
            upth_r    <= tks_pkg::UPTH_RST;
            scans_r   <= tks_pkg::SCANS_RST;
            irq_mask_r <= '0;
        end
        else
        begin
            if (wr_hit(tks_pkg::REG_CTRL))
                ctrl_r <= wdata;
            else if (scan_done && (mode != tks_pkg::TKS_MODE_PERIODIC))
                ctrl_r[tks_pkg::CTRL_START_BIT] <= 1'b0;
            if (wr_hit(tks_pkg::REG_KEYEN))
                keyen_r <= wdata[NKEYS-1:0];
            if (wr_hit(tks_pkg::REG_THDIR))
                thdir_r <= wdata[NKEYS-1:0];
            if (wr_hit(tks_pkg::REG_SLOTLEN))
                slotlen_r <= wdata;
            if (wr_hit(tks_pkg::REG_LOWTH))
                lowth_r <= wdata;
            if (wr_hit(tks_pkg::REG_UPTH))
                upth_r <= wdata;
            if (wr_hit(tks_pkg::REG_SCANS))
                scans_r <= wdata;
            if (wr_hit(tks_pkg::REG_IRQ_MASK))
                irq_mask_r <= wdata[tks_pkg::IRQ_W-1:0];
        end
    end

    // Scan sequencer: start edge begins at the first enabled key
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            start_d_r  <= 1'b0;
            busy_r     <= 1'b0;
            slot_r     <= 2'h0;
            scan_cnt_r <= '0;
            osc_sync   <= 1'b0;
        end
        else
        begin
            start_d_r <= ctrl_r[tks_pkg::CTRL_START_BIT];
            osc_sync  <= start_rise;
            if (start_rise && (|keyen_r))
            begin
                busy_r     <= 1'b1;
                slot_r     <= first_en(2'h0, keyen_r);
                scan_cnt_r <= '0;
            end
            else if (start_fall || scan_done)
                busy_r <= 1'b0;
            else if (seq_end)
            begin
                slot_r     <= first_en(2'h0, keyen_r);
                scan_cnt_r <= scan_cnt_r + 16'h1;
            end
            else if (ev.slot_end)
                slot_r <= next_slot;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            osc_enable <= '0;
        else if (busy_r && !scan_done && !start_fall)
            osc_enable <= keyen_r & (NKEYS'(1) << slot_r);
        else
            osc_enable <= '0;
    end

    // Periodic mode stores only the last slot of the final scan; other modes store every slot
    always_ff @(posedge clk)
    begin
        if (ev.slot_end && ((mode != tks_pkg::TKS_MODE_PERIODIC) || scan_done))
            cf_mem[slot_r] <= cf_count;
    end

    // Sticky flags: hardware set wins over a same-cycle software clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slot_ov_r <= 1'b0;
            cf_ov_r   <= 1'b0;
            ref_ov_r  <= 1'b0;
            thflag_r  <= '0;
        end
        else
        begin
            if (mode == tks_pkg::TKS_MODE_PERIODIC && busy_r && !scan_done)
                slot_ov_r <= 1'b0;
            else if ((mode == tks_pkg::TKS_MODE_MANUAL && ev.slot_end) || scan_done)
                slot_ov_r <= 1'b1;
            else if (wr_hit(tks_pkg::REG_FLAGS) && wdata[tks_pkg::FLG_SLOT_OV])
                slot_ov_r <= 1'b0;
            if (ev.cf_ov)
                cf_ov_r <= 1'b1;
            else if (wr_hit(tks_pkg::REG_FLAGS) && wdata[tks_pkg::FLG_CF_OV])
                cf_ov_r <= 1'b0;
            if (ev.ref_ov)
                ref_ov_r <= 1'b1;
            else if (wr_hit(tks_pkg::REG_FLAGS) && wdata[tks_pkg::FLG_REF_OV])
                ref_ov_r <= 1'b0;
            if (wr_hit(tks_pkg::REG_THDIR))
                thflag_r <= '0;
            if (thr_hit)
                thflag_r[slot_r] <= 1'b1;
        end
    end

    // Two independent sources; reading the status clears it, events win
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq_stat_r <= '0;
        else
        begin
            irq_stat_r[tks_pkg::IRQ_SCAN_DONE] <= ((mode == tks_pkg::TKS_MODE_MANUAL)
                && ev.slot_end) || scan_done
                || (irq_stat_r[tks_pkg::IRQ_SCAN_DONE] && !(rd && addr == tks_pkg::REG_IRQ_STAT));
            irq_stat_r[tks_pkg::IRQ_THRESH] <= thr_hit
                || (irq_stat_r[tks_pkg::IRQ_THRESH] && !(rd && addr == tks_pkg::REG_IRQ_STAT));
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_mask_r);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                tks_pkg::REG_CTRL:     rdata <= ctrl_r;
                tks_pkg::REG_KEYEN:    rdata <= 16'(keyen_r);
                tks_pkg::REG_THDIR:    rdata <= {8'(thflag_r), 8'(thdir_r)};
                tks_pkg::REG_FLAGS:    rdata <= {12'h000, busy_r, ref_ov_r, cf_ov_r, slot_ov_r};
                tks_pkg::REG_IRQ_STAT: rdata <= 16'(irq_stat_r);
                tks_pkg::REG_IRQ_MASK: rdata <= 16'(irq_mask_r);
                tks_pkg::REG_SLOTLEN:  rdata <= slotlen_r;
                tks_pkg::REG_LOWTH:    rdata <= lowth_r;
                tks_pkg::REG_UPTH:     rdata <= upth_r;
                tks_pkg::REG_SCANS:    rdata <= scans_r;
                default:
                    rdata <= (addr >= tks_pkg::REG_CFDATA0
                              && addr < tks_pkg::REG_CFDATA0 + 4'(NKEYS))
                             ? cf_mem[2'(addr - tks_pkg::REG_CFDATA0)] : 16'h0000;
            endcase
        end
        else
            rdata <= '0;
    end

    // period_tick is the watchdog-derived pacing; kept as an input for later pacing use
    logic unused_tick;
    assign unused_tick = period_tick;

    // Plain signal, not the helper function: a function body would read
    // the bus after the edge instead of the sampled values
    logic                   flags_wr;
    assign flags_wr = wr && (addr == tks_pkg::REG_FLAGS);

    sequence seq_manual_end;
        (mode == tks_pkg::TKS_MODE_MANUAL) && ev.slot_end;
    endsequence

    sequence seq_periodic_run;
        (mode == tks_pkg::TKS_MODE_PERIODIC) && busy_r && !scan_done;
    endsequence

    sequence seq_slot_close;
        ev.slot_end;
    endsequence

    AST_MANUAL_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        seq_manual_end |=> slot_ov_r && irq_stat_r[tks_pkg::IRQ_SCAN_DONE])
        else $error("manual slot end did not set flag");
    AST_AUTO_NOFLAG: assert property (@(posedge clk) disable iff (!resetn)
        (mode == tks_pkg::TKS_MODE_AUTO && !slot_ov_r && !seq_end) |=> !slot_ov_r)
        else $error("auto flag set mid sequence");
    AST_PERIODIC_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        seq_periodic_run |=> !slot_ov_r)
        else $error("periodic flag not held low");
    AST_DONE_IRQ: assert property (@(posedge clk) disable iff (!resetn)
        scan_done |=> irq_stat_r[tks_pkg::IRQ_SCAN_DONE] && slot_ov_r)
        else $error("scan done request missing");
    AST_CF_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        (ev.cf_ov || (cf_ov_r && !flags_wr)) |=> cf_ov_r)
        else $error("cf overflow flag lost");
    AST_REF_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        (ev.ref_ov || (ref_ov_r && !flags_wr)) |=> ref_ov_r)
        else $error("ref overflow flag lost");
    AST_SLOT_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        (slot_ov_r && !flags_wr && !(mode == tks_pkg::TKS_MODE_PERIODIC
         && busy_r)) |=> slot_ov_r)
        else $error("slot flag cleared by hardware");
    AST_THRESH: assert property (@(posedge clk) disable iff (!resetn)
        thr_hit |=> irq_stat_r[tks_pkg::IRQ_THRESH] && thflag_r[$past(slot_r)])
        else $error("threshold event not recorded");
    AST_KEY_EN: assert property (@(posedge clk) disable iff (!resetn)
        (osc_enable & ~keyen_r) == '0 || $changed(keyen_r))
        else $error("disabled key oscillator on");
    AST_SYNC_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        start_rise |=> osc_sync)
        else $error("start edge gave no sync pulse");
    AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        seq_slot_close |=> (cf_count == '0))
        else $error("count not cleared at slot end");
    AST_ABORT_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        start_fall |=> (cf_count == '0))
        else $error("count not cleared on start clear");

endmodule

// [test/tks_osc_model.sv]
`timescale 1ns/1ps

// Key and reference oscillators of the electrodes; both stop while no key is enabled
module tks_osc_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] osc_enable,
    input  wire logic [7:0] key_div,
    output      logic       key_tick,
    output      logic       ref_tick
);
    logic [7:0] kc_r;
    logic [1:0] rc_r;

    // Reference runs at a quarter of the clock, key at clk/key_div
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            kc_r     <= 8'h00;
            rc_r     <= 2'h0;
            key_tick <= 1'b0;
            ref_tick <= 1'b0;
        end
        else if (osc_enable == 4'h0)
        begin
            kc_r     <= 8'h00;
            rc_r     <= 2'h0;
            key_tick <= 1'b0;
            ref_tick <= 1'b0;
        end
        else
        begin
            key_tick <= (kc_r == 8'h00);
            kc_r     <= (kc_r >= key_div - 8'h01) ? 8'h00 : kc_r + 8'h01;
            ref_tick <= (rc_r == 2'h0);
            rc_r     <= rc_r + 2'h1;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    logic        clk;
    logic        resetn;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        key_tick;
    logic        ref_tick;
    logic        period_tick;
    logic [3:0]  osc_enable;
    logic        osc_sync;
    logic        irq;
    logic [7:0]  key_div;
    logic [3:0]  seen_en;
    logic [15:0] v;
    int          bad_count;
    int          checked;
    int          sync_cnt;
    int          cycles;
    int          s0;

    tks_scan_flags u_dut (
        .clk         (clk),
        .resetn      (resetn),
        .addr        (addr),
        .wdata       (wdata),
        .wr          (wr),
        .rd          (rd),
        .rdata       (rdata),
        .key_tick    (key_tick),
        .ref_tick    (ref_tick),
        .period_tick (period_tick),
        .osc_enable  (osc_enable),
        .osc_sync    (osc_sync),
        .irq         (irq)
    );

    tks_osc_model u_osc (
        .clk        (clk),
        .resetn     (resetn),
        .osc_enable (osc_enable),
        .key_div    (key_div),
        .key_tick   (key_tick),
        .ref_tick   (ref_tick)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Scan monitor: which keys were ever driven, and how many sync pulses
    always @(posedge clk)
    begin
        seen_en = seen_en | osc_enable;
        if (osc_sync === 1'b1)
            sync_cnt = sync_cnt + 1;
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        reg_rd(a, d);
        chk(name, d, exp);
    endtask

    // Poll until busy drops; while busy the slot flag must stay low if mid is set
    task automatic wait_idle(input bit mid);
        logic [15:0] d;
        repeat (4) @(posedge clk);
        d = 16'h0008;
        for (int i = 0; i < 600 && d[3] !== 1'b0; i++)
        begin
            reg_rd(tks_pkg::REG_FLAGS, d);
            if (mid && d[3] === 1'b1)
                chk("slot flag mid scan", {15'h0000, d[0]}, 16'h0000);
        end
        chk("busy", {15'h0000, d[3]}, 16'h0000);
    endtask

    initial
    begin
        resetn      = 1'b0;
        addr        = 4'h0;
        wdata       = 16'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        period_tick = 1'b0;
        key_div     = 8'h01;
        seen_en     = 4'h0;
        bad_count   = 0;
        checked     = 0;
        sync_cnt    = 0;
        cycles      = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd_chk("slotlen", tks_pkg::REG_SLOTLEN, tks_pkg::SLOTLEN_RST);
        rd_chk("upth", tks_pkg::REG_UPTH, tks_pkg::UPTH_RST);
        rd_chk("scans", tks_pkg::REG_SCANS, tks_pkg::SCANS_RST);
        rd_chk("ctrl", tks_pkg::REG_CTRL, tks_pkg::CTRL_RST);
        rd_chk("flags", tks_pkg::REG_FLAGS, 16'h0000);
        rd_chk("unmapped", 4'hF, 16'h0000);

        // Manual scan of key 0 with the interrupt masked
        reg_wr(tks_pkg::REG_KEYEN, 16'h0001);
        reg_wr(tks_pkg::REG_SLOTLEN, 16'h0000);
        reg_wr(tks_pkg::REG_IRQ_MASK, 16'h0000);
        seen_en = 4'h0;
        s0 = sync_cnt;
        reg_wr(tks_pkg::REG_CTRL, 16'h0003);
        wait_idle(1'b0);
        chk("sync pulses", 16'(sync_cnt - s0), 16'h0001);
        chk("keys scanned", {12'h000, seen_en}, 16'h0001);
        chk("osc after done", {12'h000, osc_enable}, 16'h0000);
        rd_chk("flags manual", tks_pkg::REG_FLAGS, 16'h0001);
        rd_chk("ctrl start cleared", tks_pkg::REG_CTRL, 16'h0002);
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        reg_wr(tks_pkg::REG_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge clk);
        chk("irq unmasked", {15'h0000, irq}, 16'h0001);
        rd_chk("irq stat manual", tks_pkg::REG_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irq after read", {15'h0000, irq}, 16'h0000);
        rd_chk("irq stat cleared", tks_pkg::REG_IRQ_STAT, 16'h0000);
        repeat (50) @(posedge clk);
        rd_chk("flag sticky", tks_pkg::REG_FLAGS, 16'h0001);
        reg_wr(tks_pkg::REG_FLAGS, 16'h0001);
        rd_chk("flag cleared", tks_pkg::REG_FLAGS, 16'h0000);

        // Auto scan over keys 0 and 2; key 1 stays out
        reg_wr(tks_pkg::REG_KEYEN, 16'h0005);
        seen_en = 4'h0;
        reg_wr(tks_pkg::REG_CTRL, 16'h0001);
        wait_idle(1'b1);
        chk("keys auto", {12'h000, seen_en}, 16'h0005);
        rd_chk("flags auto", tks_pkg::REG_FLAGS, 16'h0001);
        rd_chk("irq stat auto", tks_pkg::REG_IRQ_STAT, 16'h0001);
        reg_wr(tks_pkg::REG_FLAGS, 16'h0001);

        // Periodic, mode 10, key 0 counts above the upper threshold
        reg_wr(tks_pkg::REG_KEYEN, 16'h0001);
        reg_wr(tks_pkg::REG_SCANS, 16'h0002);
        reg_wr(tks_pkg::REG_UPTH, 16'h0010);
        reg_wr(tks_pkg::REG_THDIR, 16'h0001);
        reg_wr(tks_pkg::REG_CTRL, 16'h0005);
        wait_idle(1'b1);
        rd_chk("flags periodic", tks_pkg::REG_FLAGS, 16'h0001);
        rd_chk("irq stat periodic", tks_pkg::REG_IRQ_STAT, 16'h0003);
        rd_chk("thresh above", tks_pkg::REG_THDIR, 16'h0101);
        reg_rd(tks_pkg::REG_CFDATA0, v);
        chk("stored count", {15'h0000, v > 16'h0010}, 16'h0001);
        reg_wr(tks_pkg::REG_CTRL, 16'h0000);
        reg_wr(tks_pkg::REG_FLAGS, 16'h0001);

        // Periodic, mode 11, slow key counts below the lower threshold
        key_div <= 8'h04;
        reg_wr(tks_pkg::REG_THDIR, 16'h0000);
        reg_wr(tks_pkg::REG_LOWTH, 16'h0100);
        reg_wr(tks_pkg::REG_CTRL, 16'h0007);
        wait_idle(1'b1);
        rd_chk("thresh below", tks_pkg::REG_THDIR, 16'h0100);
        rd_chk("irq stat mode 11", tks_pkg::REG_IRQ_STAT, 16'h0003);
        reg_wr(tks_pkg::REG_CTRL, 16'h0000);
        reg_wr(tks_pkg::REG_FLAGS, 16'h0001);

        // Abort an auto scan by clearing start; oscillators stop, no flag
        reg_wr(tks_pkg::REG_KEYEN, 16'h0005);
        reg_wr(tks_pkg::REG_CTRL, 16'h0001);
        repeat (20) @(posedge clk);
        reg_wr(tks_pkg::REG_CTRL, 16'h0000);
        repeat (3) @(posedge clk);
        chk("osc after abort", {12'h000, osc_enable}, 16'h0000);
        rd_chk("flags after abort", tks_pkg::REG_FLAGS, 16'h0000);

        // Single-slot auto scan: only the first enabled key takes part
        seen_en = 4'h0;
        reg_wr(tks_pkg::REG_CTRL, 16'h0009);
        wait_idle(1'b1);
        chk("keys single slot", {12'h000, seen_en}, 16'h0001);
        rd_chk("flags single slot", tks_pkg::REG_FLAGS, 16'h0001);
        tally_and_finish();
    end
endmodule
